// File: dv/serial_flash_fifo_datapath_tb.sv
`include "sfd_regs.svh"

module serial_flash_fifo_datapath_tb
  import sfd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [31:0] C_START = 32'h1 << `SFD_B_START;
  localparam logic [31:0] C_STOP  = 32'h1 << `SFD_B_STOP;
  localparam logic [31:0] C_DIR   = 32'h1 << `SFD_B_RW;
  localparam logic [31:0] C_LEN   = 32'h1 << `SFD_B_BLEN;

  logic        clock;
  logic        rst_n;
  logic [5:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        irq;
  logic        sclk;
  logic        cs_n;
  logic        sio_out;
  logic        sio_oe;
  logic        sio_in;
  logic [31:0] q;
  logic [31:0] w[9];
  logic [31:0] loc;
  logic [15:0] opc;
  logic [15:0] md;
  logic        eb[$];
  int          failures;
  int          checks;
  int          n;

  sfd_top #(.SCK_HALF(6), .DEPTH(8)) dut
  (
    .clock(clock), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .sclk(sclk), .cs_n(cs_n),
    .sio_out(sio_out), .sio_oe(sio_oe), .sio_in(sio_in)
  );

  sfd_flash_model fm
  (
    .clock(clock), .sclk(sclk), .cs_n(cs_n), .sio_out(sio_out), .sio_oe(sio_oe),
    .sio_in(sio_in)
  );

  always #5 clock = ~clock;

  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic results();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic rd, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clock);
    avs_address   <= a;
    avs_read      <= rd;
    avs_write     <= !rd;
    avs_writedata <= d;
    do
    begin
      @(posedge clock);
    end
    while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] t;
    bus(1'b0, a, d, t);
  endtask

  task automatic rd(input logic [5:0] a, output logic [31:0] r);
    bus(1'b1, a, 32'h0, r);
  endtask

  task automatic put_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
      eb.push_back(b[i]);
  endtask

  task automatic wait_bits(input int nb);
    int k;
    k = 0;
    while (fm.cap.size() < nb && k < 8000)
    begin
      @(posedge clock);
      k++;
    end
  endtask

  // No serial clock may move while the select stays low
  task automatic stall();
    int k;
    k = 0;
    repeat (20) @(posedge clock);
    repeat (60)
    begin
      @(posedge clock);
      if (sclk !== 1'b0 || cs_n !== 1'b0)
        k++;
    end
    chk(k, 0);
  endtask

  task automatic stop_and_end(input logic [31:0] conf);
    int k;
    wr(`SFD_OFF_CONF, conf | C_STOP);
    k = 0;
    while (cs_n !== 1'b1 && k < 5000)
    begin
      @(posedge clock);
      k++;
    end
    chk({31'h0, cs_n}, 32'h1);
  endtask

  task automatic cmp_bits();
    chk(fm.cap.size(), eb.size());
    foreach (eb[i])
      if (i < fm.cap.size())
        chk({31'h0, fm.cap[i]}, {31'h0, eb[i]});
  endtask

  initial
  begin
    repeat (50000) @(posedge clock);
    failures++;
    results();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    clock = 1'b0;
    rst_n = 1'b0;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    failures = 0;
    checks = 0;
    void'($urandom(32'hec643a5f));
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);

    rd(`SFD_OFF_STAT, q);
    chk(q, 32'h0000_0050);
    rd(`SFD_OFF_TXD, q);
    chk(q, 32'h0);
    rd(`SFD_OFF_OPC, q);
    chk(q, 32'h0);
    rd(6'h3c, q);
    chk(q, 32'h0);
    $display("test reset values done");

    // Full header, four-byte words, then an empty queue
    opc = $urandom;
    loc = $urandom;
    md = $urandom;
    wr(`SFD_OFF_HDR, 32'h0000_1112);
    wr(`SFD_OFF_OPC, {16'h0, opc});
    wr(`SFD_OFF_LOC, loc);
    wr(`SFD_OFF_MODE, {16'h0, md});
    eb.delete();
    put_byte(opc[15:8]);
    put_byte(opc[7:0]);
    put_byte(loc[7:0]);
    put_byte(md[7:0]);
    put_byte(8'h00);
    w[0] = $urandom;
    w[1] = 32'h8000_0001;
    for (int i = 0; i < 2; i++)
    begin
      wr(`SFD_OFF_TXD, w[i]);
      for (int k = 0; k < 4; k++)
        put_byte(w[i][8*k+:8]);
    end
    fm.cap.delete();
    wr(`SFD_OFF_CONF, C_START | C_DIR | C_LEN);
    wait_bits(104);
    stall();
    w[2] = $urandom;
    wr(`SFD_OFF_TXD, w[2]);
    for (int k = 0; k < 4; k++)
      put_byte(w[2][8*k+:8]);
    wait_bits(136);
    stop_and_end(C_START | C_DIR | C_LEN);
    cmp_bits();
    rd(`SFD_OFF_ISTAT, q);
    chk(q[`SFD_I_DONE], 1'b1);
    wr(`SFD_OFF_ICLR, 32'h7);
    $display("test four-byte write done");

    // Overrun on a full queue, then one-byte drain
    opc = $urandom;
    wr(`SFD_OFF_HDR, 32'h1);
    wr(`SFD_OFF_OPC, {16'h0, opc});
    wr(`SFD_OFF_IEN, 32'h1 << `SFD_I_TXOVR);
    eb.delete();
    put_byte(opc[7:0]);
    for (int i = 0; i < 9; i++)
    begin
      w[i] = $urandom;
      wr(`SFD_OFF_TXD, w[i]);
      if (i < 8)
        put_byte(w[i][7:0]);
      if (i == 7)
      begin
        rd(`SFD_OFF_STAT, q);
        chk(q[`SFD_B_TXSAT], 1'b1);
      end
    end
    rd(`SFD_OFF_STAT, q);
    chk(q[`SFD_B_TXOVR], 1'b1);
    chk(irq, 1'b1);
    wr(`SFD_OFF_ICLR, 32'h1 << `SFD_I_TXOVR);
    repeat (2) @(posedge clock);
    chk(irq, 1'b0);
    fm.cap.delete();
    wr(`SFD_OFF_CONF, C_START | C_DIR);
    wait_bits(72);
    stall();
    stop_and_end(C_START | C_DIR);
    cmp_bits();
    wr(`SFD_OFF_ICLR, 32'h7);
    $display("test overrun and one-byte write done");

    // Read until the receive queue is full, then drain past empty
    wr(`SFD_OFF_HDR, 32'h0);
    fm.src.delete();
    for (int i = 0; i < 9; i++)
    begin
      w[i] = (i == 0) ? 32'hff00_00ff : $urandom;
      for (int k = 0; k < 4; k++)
        for (int b = 7; b >= 0; b--)
          fm.src.push_back(w[i][8*k+b]);
    end
    wr(`SFD_OFF_CONF, C_START | C_LEN);
    q = 32'h0;
    n = 0;
    while (q[`SFD_B_RXSAT] !== 1'b1 && n < 2000)
    begin
      rd(`SFD_OFF_STAT, q);
      n++;
    end
    chk(q[`SFD_B_RXSAT], 1'b1);
    stall();
    stop_and_end(C_START | C_LEN);
    wr(`SFD_OFF_IEN, 32'h1 << `SFD_I_RXUND);
    for (int i = 0; i < 8; i++)
    begin
      rd(`SFD_OFF_RXD, q);
      chk(q, w[i]);
    end
    rd(`SFD_OFF_RXD, q);
    chk(q, 32'h0);
    rd(`SFD_OFF_STAT, q);
    chk(q[`SFD_B_RXUND], 1'b1);
    chk(irq, 1'b1);
    $display("test read and underrun done");

    // One-byte read keeps the upper bits clear, flush empties the queue
    fm.src.delete();
    for (int i = 0; i < 4; i++)
    begin
      w[i] = {24'h0, 8'($urandom)};
      for (int b = 7; b >= 0; b--)
        fm.src.push_back(w[i][b]);
    end
    wr(`SFD_OFF_CONF, C_START);
    n = 0;
    while (fm.src.size() > 0 && n < 2000)
    begin
      @(posedge clock);
      n++;
    end
    stop_and_end(C_START);
    for (int i = 0; i < 3; i++)
    begin
      rd(`SFD_OFF_RXD, q);
      chk(q, w[i]);
    end
    wr(`SFD_OFF_CONF, 32'h1 << `SFD_B_FLUSH);
    rd(`SFD_OFF_STAT, q);
    chk(q[`SFD_B_RXVAC], 1'b1);
    $display("test one-byte read and flush done");
    results();
  end
endmodule // serial_flash_fifo_datapath_tb

// File: dv/sfd_flash_model.sv
// ----------------------------------------
// Serial flash stand-in: samples on rising sclk, drives on falling sclk
// ----------------------------------------
module sfd_flash_model
(
  input  wire logic clock,    // System clock, samples the link
  input  wire logic sclk,     // Serial clock from the controller
  input  wire logic cs_n,     // Select, active low
  input  wire logic sio_out,  // Controller data out
  input  wire logic sio_oe,   // Controller drive enable
  output logic      sio_in    // Data back to the controller
);
  timeunit 1ns;
  timeprecision 1ps;

  logic cap[$];          // Bits seen while the controller drives
  logic src[$];          // Bits to send during a read
  logic line_q = 1'b0;   // Level on the return line
  logic sclk_q = 1'b0;   // Serial clock one system clock ago
  logic csn_q  = 1'b1;   // Select one system clock ago

  assign sio_in = line_q;

  // One process: samples after rising sclk, drives after falling sclk or select
  always @(posedge clock)
  begin
    sclk_q <= sclk;
    csn_q  <= cs_n;
    if (cs_n)
      line_q <= ~line_q;  // Deselected: no value can be relied on
    else if (csn_q || (sclk_q && !sclk))
    begin
      if (src.size() > 0)
        line_q <= src.pop_front();
      else
        line_q <= ~line_q;  // Exhausted source: no stale value
    end
    if (!cs_n && sio_oe && !sclk_q && sclk)
      cap.push_back(sio_out);
  end
endmodule // sfd_flash_model

// File: rtl/sfd_pkg.sv
package sfd_pkg;

  typedef enum logic [5:0]
  {
    SFD_PH_IDLE  = 6'h01,
    SFD_PH_OPC   = 6'h02,
    SFD_PH_LOC   = 6'h04,
    SFD_PH_MODE  = 6'h08,
    SFD_PH_DUMMY = 6'h10,
    SFD_PH_DATA  = 6'h20
  } sfd_phase_e;

endpackage

// File: rtl/sfd_regs.svh
`ifndef SFD_REGS_SVH
`define SFD_REGS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SFD_OFF_STAT  6'h00
`define SFD_OFF_CONF  6'h04
`define SFD_OFF_TXD   6'h08
`define SFD_OFF_RXD   6'h0c
`define SFD_OFF_OPC   6'h10
`define SFD_OFF_LOC   6'h14
`define SFD_OFF_MODE  6'h18
`define SFD_OFF_HDR   6'h1c
`define SFD_OFF_ISTAT 6'h24
`define SFD_OFF_ICLR  6'h28
`define SFD_OFF_IEN   6'h2c

// ----------------------------------------
// Control field positions
// ----------------------------------------
`define SFD_B_START 15
`define SFD_B_STOP  14
`define SFD_B_RW    13
`define SFD_B_FLUSH 9
`define SFD_B_BLEN  5

// ----------------------------------------
// Status field positions
// ----------------------------------------
`define SFD_B_TXOVR 11
`define SFD_B_RXUND 8
`define SFD_B_TXSAT 7
`define SFD_B_TXVAC 6
`define SFD_B_RXSAT 5
`define SFD_B_RXVAC 4
`define SFD_B_BUSY  0

// ----------------------------------------
// Interrupt bits and reset values
// ----------------------------------------
`define SFD_I_TXOVR 0
`define SFD_I_RXUND 1
`define SFD_I_DONE  2
`define SFD_RST_W32 32'h0000_0000
`define SFD_RST_W16 16'h0000

`endif

// File: rtl/sfd_top.sv
// Functional notes
// - Each transmit-port write pushes its word into an 8x32 queue unless the queue is full.
// - Queue data goes out only after opcode, location, mode and dummy bytes.
// - Serial clock halts while the transmit queue is empty.
// - One-byte length sends only bits 7:0, msb first.
// - Four-byte length sends bytes low to high, each msb first.
// - Writing a full transmit queue sets overrun; host checks full first.
// - Read transfers shift serial input into an 8x32 queue read via port.
// - Serial clock halts while the receive queue is full.
// - One-byte mode fills bits 7:0; four-byte fills low byte up to top.
// - Reading an empty receive queue sets underrun; host checks empty first.
// - Setting start begins the transfer with the opcode bytes.
// - Opcode count 0 sends none, 1 low byte, 2 high then low.
// - Direction bit clear reads, set writes.
// - Length bit clear is one byte, set is four bytes.
`include "sfd_regs.svh"

module sfd_top
  import sfd_pkg::*;
#(
  parameter int SCK_HALF = 4,                 // System clocks per serial half period
  parameter int DEPTH    = 8                  // Entries per queue
)
(
  input  wire logic        clock,             // 100 MHz
  input  wire logic        rst_n,             // Async reset
  input  wire logic [5:0]  avs_address,       // Byte address
  input  wire logic        avs_read,          // Read request
  input  wire logic        avs_write,         // Write request
  input  wire logic [31:0] avs_writedata,     // Write data
  output logic      [31:0] avs_readdata,      // Read data
  output logic             avs_waitrequest,   // Stall
  output logic             irq,               // Level interrupt
  output logic             sclk,              // Serial clock
  output logic             cs_n,              // Flash select
  output logic             sio_out,           // Serial data out
  output logic             sio_oe,            // Serial data enable
  input  wire logic        sio_in             // Serial data in
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = 8;

  // ----------------------------------------
  // Reset and input synchronisers
  // ----------------------------------------
  logic rst_s1_q, rst_n_q, sin_s1_q, sin_s2_q;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  always_ff @(posedge clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      sin_s1_q <= 1'b0;
      sin_s2_q <= 1'b0;
    end
    else
    begin
      sin_s1_q <= sio_in;
      sin_s2_q <= sin_s1_q;
    end
  end

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic             start_q, stop_q, rw_q, blen_q, rvld_q;
  logic [15:0]      opc_q, mode_q;
  logic [31:0]      loc_q, txd_q, rdata_q, word_q, rxw_q;
  logic [1:0]       icnt_q, mcnt_q, dcnt_q, wb_q;
  logic [2:0]       lcnt_q, ien_q, ist_q, left_q, bit_q;
  sfd_phase_e       ph_q;
  logic             load_q, sclk_q, csn_q;
  logic [7:0]       sh_q, rxs_q;
  logic [CW-1:0]    div_q;
  logic [31:0]      tx_mem [DEPTH];
  logic [31:0]      rx_mem [DEPTH];
  logic [AW:0]      tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q, tx_cnt, rx_cnt;
  logic             rd_go, wr_tx, rd_rx, tx_push, tx_pop, rx_push, rx_pop;
  logic             tx_vac, tx_sat, rx_vac, rx_sat, ovr_ev, und_ev, done;
  logic             flush, tick, in_data, wlast, byte_end;
  logic [31:0]      tx_head, rx_pdata, rmux;
  logic [2:0]       iclr;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  assign rd_go   = avs_read & ~rvld_q;
  assign avs_waitrequest = rd_go;
  assign avs_readdata    = rdata_q;
  assign wr_tx   = avs_write && avs_address == `SFD_OFF_TXD;
  assign rd_rx   = rd_go && avs_address == `SFD_OFF_RXD;
  assign tx_push = wr_tx && !tx_sat;
  assign ovr_ev  = wr_tx && tx_sat;
  assign rx_pop  = rd_rx && !rx_vac;
  assign und_ev  = rd_rx && rx_vac;
  assign flush   = avs_write && avs_address == `SFD_OFF_CONF && avs_writedata[`SFD_B_FLUSH];
  assign iclr    = (avs_write && avs_address == `SFD_OFF_ICLR) ? avs_writedata[2:0] : 3'h0;

  always_comb
  begin
    rmux = `SFD_RST_W32;
    unique case (avs_address)
      `SFD_OFF_STAT:
      begin
        rmux[`SFD_B_TXOVR] = ist_q[`SFD_I_TXOVR];
        rmux[`SFD_B_RXUND] = ist_q[`SFD_I_RXUND];
        rmux[`SFD_B_TXSAT] = tx_sat;
        rmux[`SFD_B_TXVAC] = tx_vac;
        rmux[`SFD_B_RXSAT] = rx_sat;
        rmux[`SFD_B_RXVAC] = rx_vac;
        rmux[`SFD_B_BUSY]  = !csn_q;
      end
      `SFD_OFF_CONF:
      begin
        rmux[`SFD_B_START] = start_q;
        rmux[`SFD_B_STOP]  = stop_q;
        rmux[`SFD_B_RW]    = rw_q;
        rmux[`SFD_B_BLEN]  = blen_q;
      end
      `SFD_OFF_TXD:   rmux = txd_q;
      `SFD_OFF_RXD:   rmux = rx_vac ? `SFD_RST_W32 : rx_mem[rx_rp_q[AW-1:0]];
      `SFD_OFF_OPC:   rmux[15:0] = opc_q;
      `SFD_OFF_LOC:   rmux = loc_q;
      `SFD_OFF_MODE:  rmux[15:0] = mode_q;
      `SFD_OFF_HDR:   rmux[13:0] = {dcnt_q, 2'h0, mcnt_q, 1'b0, lcnt_q, 2'h0, icnt_q};
      `SFD_OFF_ISTAT: rmux[2:0] = ist_q;
      `SFD_OFF_IEN:   rmux[2:0] = ien_q;
      default:        rmux = `SFD_RST_W32;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      rvld_q  <= 1'b0;
      rdata_q <= `SFD_RST_W32;
    end
    else
    begin
      rvld_q <= rd_go;
      if (rd_go)
        rdata_q <= rmux;
    end
  end

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      {start_q, stop_q, rw_q, blen_q} <= 4'h0;
      {opc_q, mode_q} <= {`SFD_RST_W16, `SFD_RST_W16};
      {loc_q, txd_q}  <= {`SFD_RST_W32, `SFD_RST_W32};
      {icnt_q, mcnt_q, dcnt_q, lcnt_q, ien_q} <= 12'h000;
    end
    else
    begin
      if (avs_write)
      begin
        unique case (avs_address)
          `SFD_OFF_CONF:
          begin
            start_q <= avs_writedata[`SFD_B_START];
            stop_q  <= avs_writedata[`SFD_B_STOP];
            rw_q    <= avs_writedata[`SFD_B_RW];
            blen_q  <= avs_writedata[`SFD_B_BLEN];
          end
          `SFD_OFF_TXD:  txd_q  <= avs_writedata;
          `SFD_OFF_OPC:  opc_q  <= avs_writedata[15:0];
          `SFD_OFF_LOC:  loc_q  <= avs_writedata;
          `SFD_OFF_MODE: mode_q <= avs_writedata[15:0];
          `SFD_OFF_HDR:
          begin
            icnt_q <= avs_writedata[1:0];
            lcnt_q <= avs_writedata[6:4];
            mcnt_q <= avs_writedata[9:8];
            dcnt_q <= avs_writedata[13:12];
          end
          `SFD_OFF_IEN:  ien_q  <= avs_writedata[2:0];
          default:       ;
        endcase
      end
      if (done)
      begin
        start_q <= 1'b0;
        stop_q  <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Interrupts: set wins over clear
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
      ist_q <= 3'h0;
    else
      ist_q <= (ist_q & ~iclr) | {done, und_ev, ovr_ev};
  end

  assign irq = |(ist_q & ien_q);

  // ----------------------------------------
  // Queues
  // ----------------------------------------
  assign tx_cnt  = tx_wp_q - tx_rp_q;
  assign rx_cnt  = rx_wp_q - rx_rp_q;
  assign tx_vac  = tx_cnt == '0;
  assign tx_sat  = tx_cnt == (AW+1)'(DEPTH);
  assign rx_vac  = rx_cnt == '0;
  assign rx_sat  = rx_cnt == (AW+1)'(DEPTH);
  assign tx_head = tx_mem[tx_rp_q[AW-1:0]];

  for (genvar i = 0; i < DEPTH; i++)
  begin : g_ent
    always_ff @(posedge clock)
    begin
      if (tx_push && tx_wp_q[AW-1:0] == AW'(i))
        tx_mem[i] <= avs_writedata;
      if (rx_push && rx_wp_q[AW-1:0] == AW'(i))
        rx_mem[i] <= rx_pdata;
    end
  end

  always_ff @(posedge clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
      {tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q} <= '0;
    else if (flush)
      {tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q} <= '0;
    else
    begin
      tx_wp_q <= tx_wp_q + (AW+1)'(tx_push);
      tx_rp_q <= tx_rp_q + (AW+1)'(tx_pop);
      rx_wp_q <= rx_wp_q + (AW+1)'(rx_push);
      rx_rp_q <= rx_rp_q + (AW+1)'(rx_pop);
    end
  end

  // ----------------------------------------
  // Serial engine
  // ----------------------------------------
  assign tick     = div_q == CW'(SCK_HALF - 1);
  assign in_data  = ph_q == SFD_PH_DATA;
  assign wlast    = blen_q ? (wb_q == 2'h3) : 1'b1;
  assign byte_end = !load_q && tick && sclk_q && bit_q == 3'h7;
  assign tx_pop   = load_q && in_data && rw_q && wb_q == 2'h0 && !stop_q && !tx_vac;
  assign rx_push  = byte_end && in_data && !rw_q && wlast;
  assign rx_pdata = blen_q ? {rxs_q, rxw_q[23:0]} : {24'h0, rxs_q};
  assign done     = load_q && in_data && wb_q == 2'h0 && stop_q;
  assign sclk     = sclk_q;
  assign cs_n     = csn_q;
  assign sio_out  = sh_q[7];
  assign sio_oe   = !csn_q && !(in_data && !rw_q);

  always_ff @(posedge clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
      div_q <= '0;
    else if (csn_q || load_q || tick)
      div_q <= '0;
    else
      div_q <= div_q + 1'b1;
  end

  always_ff @(posedge clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      ph_q   <= SFD_PH_IDLE;
      {left_q, bit_q, wb_q} <= 8'h00;
      {load_q, sclk_q, csn_q} <= 3'b101;
      {sh_q, rxs_q} <= 16'h0000;
      {word_q, rxw_q} <= {`SFD_RST_W32, `SFD_RST_W32};
    end
    else if (load_q)
    begin
      unique case (ph_q)
        SFD_PH_IDLE:
          if (start_q)
          begin
            ph_q   <= SFD_PH_OPC;
            left_q <= {1'b0, icnt_q};
            csn_q  <= 1'b0;
            {bit_q, wb_q} <= 5'h00;
          end
        SFD_PH_OPC:
          if (left_q == 3'h0)
          begin
            ph_q   <= SFD_PH_LOC;
            left_q <= lcnt_q;
          end
          else
          begin
            sh_q   <= (left_q == 3'h2) ? opc_q[15:8] : opc_q[7:0];
            left_q <= left_q - 3'h1;
            load_q <= 1'b0;
          end
        SFD_PH_LOC:
          if (left_q == 3'h0)
          begin
            ph_q   <= SFD_PH_MODE;
            left_q <= {1'b0, mcnt_q};
          end
          else
          begin
            sh_q   <= loc_q[{left_q[1:0] - 2'h1, 3'h0} +: 8];
            left_q <= left_q - 3'h1;
            load_q <= 1'b0;
          end
        SFD_PH_MODE:
          if (left_q == 3'h0)
          begin
            ph_q   <= SFD_PH_DUMMY;
            left_q <= {1'b0, dcnt_q};
          end
          else
          begin
            sh_q   <= (left_q == 3'h2) ? mode_q[15:8] : mode_q[7:0];
            left_q <= left_q - 3'h1;
            load_q <= 1'b0;
          end
        SFD_PH_DUMMY:
          if (left_q == 3'h0)
            ph_q <= SFD_PH_DATA;
          else
          begin
            sh_q   <= 8'h00;
            left_q <= left_q - 3'h1;
            load_q <= 1'b0;
          end
        SFD_PH_DATA:
          if (done)
          begin
            ph_q  <= SFD_PH_IDLE;
            csn_q <= 1'b1;
          end
          else if (rw_q && wb_q == 2'h0)
          begin
            if (!tx_vac)
            begin
              word_q <= tx_head;
              sh_q   <= tx_head[7:0];
              load_q <= 1'b0;
            end
          end
          else if (rw_q)
          begin
            sh_q   <= word_q[{wb_q, 3'h0} +: 8];
            load_q <= 1'b0;
          end
          else if (!(wb_q == 2'h0 && rx_sat))
          begin
            sh_q   <= 8'h00;
            load_q <= 1'b0;
          end
        default:
        begin
          ph_q  <= SFD_PH_IDLE;
          csn_q <= 1'b1;
        end
      endcase
    end
    else if (tick)
    begin
      sclk_q <= !sclk_q;
      if (!sclk_q)
        rxs_q <= {rxs_q[6:0], sin_s2_q};
      else if (bit_q == 3'h7)
      begin
        bit_q  <= 3'h0;
        load_q <= 1'b1;
        if (in_data)
        begin
          rxw_q[{wb_q, 3'h0} +: 8] <= rxs_q;
          wb_q <= wlast ? 2'h0 : wb_q + 2'h1;
        end
      end
      else
      begin
        bit_q <= bit_q + 3'h1;
        sh_q  <= {sh_q[6:0], 1'b0};
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n_q);

  AST_TX_PUSH: assert property (tx_push && !tx_pop && !flush |=>
    tx_cnt == (AW+1)'($past(tx_cnt) + 1'b1)) else $error("tx push lost");
  AST_HDR_FIRST: assert property ($rose(ph_q == SFD_PH_DATA) |->
    $past(ph_q) == SFD_PH_DUMMY) else $error("data before header");
  AST_TX_STALL: assert property (load_q && in_data && rw_q && wb_q == 2'h0 && tx_vac
    && !stop_q |=> load_q && !sclk_q) else $error("clock ran on empty queue");
  AST_ONE_BYTE: assert property (tx_pop && !blen_q |=>
    sh_q == $past(tx_head[7:0]) && sio_out == $past(tx_head[7])) else $error("bad byte");
  AST_BYTE_ORD: assert property (load_q && in_data && rw_q && blen_q && wb_q == 2'h2
    |=> sh_q == $past(word_q[23:16])) else $error("bad byte order");
  AST_OVERRUN: assert property (ovr_ev && !tx_pop |=> ist_q[`SFD_I_TXOVR] && tx_sat)
    else $error("overrun not flagged");
  AST_RX_PUSH: assert property (rx_push && !rx_pop && !flush |=>
    rx_cnt == (AW+1)'($past(rx_cnt) + 1'b1)) else $error("rx push lost");
  AST_RX_STALL: assert property (load_q && in_data && !rw_q && wb_q == 2'h0 && rx_sat
    && !stop_q |=> load_q && !sclk_q) else $error("clock ran on full queue");
  AST_RX_FILL: assert property (byte_end && in_data && !rw_q && !blen_q |->
    rx_push && rx_pdata == {24'h0, rxs_q}) else $error("bad fill");
  AST_UNDERRUN: assert property (und_ev |=> ist_q[`SFD_I_RXUND] ##1
    ist_q[`SFD_I_RXUND] || $past(iclr[`SFD_I_RXUND])) else $error("underrun lost");
  AST_START: assert property (ph_q == SFD_PH_IDLE && load_q && start_q |=>
    ph_q == SFD_PH_OPC && !cs_n) else $error("no start");
  AST_OPC_HI: assert property (load_q && ph_q == SFD_PH_OPC && left_q == 3'h2 |=>
    sh_q == $past(opc_q[15:8]) ##1 !load_q) else $error("bad opcode byte");
  AST_RD_DIR: assert property (in_data && !rw_q |-> !sio_oe)
    else $error("drove line on read");
  AST_LEN: assert property (byte_end && in_data && !blen_q |=> wb_q == 2'h0)
    else $error("bad length");

endmodule // sfd_top
